// >>> inc/rbuf_pkg.sv
// Constants and carrier types for the receive buffer block
package rbuf_pkg;
  localparam int MEM_WORDS = 2048;
  localparam int NUM_UNITS = 128;
  localparam int UNIT_SHIFT = 6;
  localparam logic [12:0] BUF_LIMIT = 13'h1FFF;
  localparam logic [12:0] SPI_BASE_3P = 13'h1000;
  localparam logic [12:0] CTL_BASE_2P = 13'h1800;
  localparam logic [12:0] CTL_BASE_3P = 13'h1C00;
  localparam logic [15:0] RBUF_BASE = 16'h2000;
  localparam logic [1:0] PART_ONE = 2'h0;
  localparam logic [1:0] PART_TWO = 2'h1;
  localparam logic [1:0] PART_THREE = 2'h2;
  localparam logic [1:0] EOPS_NONE = 2'h0;
  localparam logic [1:0] EOPS_ABORT = 2'h1;
  localparam logic [1:0] EOPS_ONE = 2'h3;
  localparam int CW_TYPE = 15;
  localparam int CW_SOP = 12;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_FREE = 4'h8;
  localparam logic [7:0] CTRL_RST = 8'h00;
  typedef enum logic [1:0] {FILL_IDLE, FILL_ACTIVE, FILL_PREVALID} fill_t;
  typedef struct packed {
    logic [15:0] rsvd;
    logic [15:0] checksum;
    logic        proto;
    logic [6:0]  element;
    logic [7:0]  byteCount;
    logic        sop;
    logic        eop;
    logic        err;
    logic        lenErr;
    logic        parErr;
    logic        abortErr;
    logic        nullBit;
    logic        typeBit;
    logic [7:0]  adr;
  } status_t;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;
  typedef struct packed {
    logic        clk;
    logic        ctl;
    logic [15:0] dat;
  } link_t;
  typedef struct packed {
    logic        start;
    logic        toDram;
    logic        pairs;
    logic [4:0]  count;
    logic [15:0] srcA;
    logic [15:0] srcB;
    logic [6:0]  xferReg;
    logic [31:0] dramAddr;
  } rd_req_t;
  typedef struct packed {
    logic        valid;
    logic [6:0]  xferReg;
    logic [31:0] data;
  } push_t;
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [63:0] data;
  } dram_t;
endpackage

// >>> rtl/rx_buffer_spi4.sv
// Receive buffer: element fill from the link, status queue, engine reads
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
// Functional notes
// - Partition modes: one (SPI-4 from 0), two (0, 0x1800), three (0, 0x1000, 0x1C00).
// - Element size per partition 64, 128 or 256 bytes, coded 00, 01, 10.
// - Transfer-register read: aligned start, count of words or pairs, consecutive registers.
// - Read address is sum of two operands; buffer window sits at 0x2000.
// - DRAM move counts 64-bit words; lower offsets go to lower DRAM addresses.
// - Reads never change data nor release elements.
// - Reset marks every element invalid.
// - Control word is held and clears checksum; idle or training words discarded.
// - Payload word needs a free element, else data dropped and overflow flagged.
// - New element copies type, status, start, port; data counted from offset 0.
// - Ones'-complement 16-bit checksum of byte pairs; odd byte takes zero high byte.
// - Control word before full validates element, end flag, count trim, queue.
// - Abort rounds byte count up to multiple of four.
// - Element filled before next control word waits pre-valid.
// - Data after pre-valid: queue it, new element same port, count 2, fresh checksum.
// - Control after pre-valid: validate with new end status and count trim.
// - Bytes stored lowest offset first, first byte in most significant lane.
// - Element number is first byte offset shifted right six.
// - Byte count 1..256, 256 coded as zero.
// - Length error when non-end burst is not a multiple of sixteen bytes.
// - Abort error from bits 14:13; summary error ORs parity, length, abort.
// - Timeout pushes null status with no element.
module rx_buffer_spi4 #(
  parameter int STQ_DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             clkEn,
  input  rbuf_pkg::wb_req_t     wbReq,
  output rbuf_pkg::status_t     wbUnused,
  output logic                  wbAck,
  output logic [31:0]           wbDatR,
  input  rbuf_pkg::link_t       linkIn,
  input  wire logic             receive_protocol_select,
  input  wire logic             dipError,
  input  wire logic             freelistTimeout,
  input  wire logic             statusTake,
  output logic                  statusValid,
  output rbuf_pkg::status_t     statusWord,
  output logic                  overflowFlag,
  input  rbuf_pkg::rd_req_t     rdReq,
  output logic                  rdBusy,
  output rbuf_pkg::push_t       pushOut,
  output rbuf_pkg::dram_t       dramOut
);
  import rbuf_pkg::*;
  localparam int PW = $clog2(STQ_DEPTH) + 1;

  typedef struct packed {
    link_t       s1;
    link_t       s2;
    logic        clkPrev;
    logic        proto1;
    logic        proto2;
    logic [7:0]  ctrl;
    logic        overflow;
    logic        pendNull;
    logic [15:0] ctlHold;
    fill_t       fsm;
    logic [6:0]  elem;
    logic [8:0]  off;
    logic [8:0]  byteCnt;
    logic [15:0] csum;
    logic [7:0]  lastByte;
    logic        tType;
    logic        tSop;
    logic [7:0]  tAdr;
    logic        tPar;
    logic [3:0]  burstCnt;
    logic [NUM_UNITS-1:0] inUse;
    logic        ack;
    logic [31:0] datR;
    status_t     stOut;
    logic        stValid;
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic        rdActive;
    logic        rdDram;
    logic        rdPhase;
    logic [10:0] rdWord;
    logic [6:0]  rdLeft;
    logic [31:0] rdLow;
    push_t       push;
    dram_t       dram;
  } state_t;

  state_t s, n;
  logic [31:0] mem [MEM_WORDS];
  status_t     fifo [STQ_DEPTH];
  logic        memWe, fifoWe, linkEdge, spiOn, found, isCtl;
  logic [10:0] memIdx;
  logic        memHigh;
  logic [15:0] memData, w;
  logic [6:0]  freeIdx;
  logic [8:0]  eBytes;
  logic [12:0] pBase, pLimit, bAddr;
  logic [1:0]  eSize;
  logic [PW-1:0] fill;
  logic [15:0] rdSum;
  status_t     fifoData;

  // Ones'-complement sum with end-around carry
  function automatic logic [15:0] ocAdd(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] t;
    t = {1'b0, a} + {1'b0, b};
    return 16'(t[15:0] + {15'h0, t[16]});
  endfunction

  // Lowest free element start inside the partition
  function automatic logic [7:0] findFree(input logic [NUM_UNITS-1:0] used,
      input logic [12:0] base, input logic [12:0] lim, input logic [1:0] esz);
    logic [12:0] o;
    logic [12:0] rel;
    findFree = 8'h00;
    for (int i = NUM_UNITS - 1; i >= 0; i--) begin
      o = 13'(i << UNIT_SHIFT);
      rel = 13'(o - base);
      if (o >= base && o <= lim && !used[i] &&
          (rel[7:0] & 8'((9'h40 << esz) - 9'h1)) == 8'h00) begin
        findFree = {1'b1, 7'(i)};
      end
    end
  endfunction

  // Status for the element being closed
  function automatic status_t closeStatus(input state_t c, input logic [1:0] eops,
      input logic byCtl);
    status_t r;
    logic [8:0] cnt;
    r = '0;
    cnt = c.byteCnt;
    r.checksum = c.csum;
    if (byCtl && eops == EOPS_ONE) begin
      cnt = 9'(c.byteCnt - 9'h1);
      r.checksum = ocAdd(ocAdd(c.csum, ~{c.lastByte, 8'h00}), {8'h00, c.lastByte});
    end
    if (byCtl && eops == EOPS_ABORT) begin
      cnt = 9'((c.byteCnt + 9'h3) & ~9'h3);
    end
    r.proto = 1'b0;
    r.element = c.elem;
    r.byteCount = cnt[7:0];
    r.sop = c.tSop;
    r.eop = byCtl && eops != EOPS_NONE;
    r.lenErr = byCtl && eops == EOPS_NONE && c.burstCnt != 4'h0;
    r.parErr = c.tPar;
    r.abortErr = byCtl && eops == EOPS_ABORT;
    r.err = r.lenErr | r.parErr | r.abortErr;
    r.typeBit = c.tType;
    r.adr = c.tAdr;
    return r;
  endfunction

  // Partition layout for the SPI-4 share of the buffer
  always_comb begin
    eSize = s.ctrl[3:2];
    pBase = '0;
    pLimit = BUF_LIMIT;
    if (s.ctrl[1:0] == PART_THREE) begin
      eSize = s.ctrl[5:4];
      pBase = SPI_BASE_3P;
      pLimit = 13'(CTL_BASE_3P - 13'h1);
    end
    eBytes = 9'(9'h40 << eSize);
    {found, freeIdx} = findFree(s.inUse, pBase, 13'(pLimit - 13'(eBytes) + 13'h1), eSize);
  end

  // Next-state logic
  always_comb begin
    n = s;
    memWe = 1'b0;
    memIdx = '0;
    memHigh = 1'b0;
    memData = '0;
    fifoWe = 1'b0;
    fifoData = '0;
    n.push.valid = 1'b0;
    n.dram.valid = 1'b0;
    fill = PW'(s.wrPtr - s.rdPtr);
    // Link synchronisers and edge detect
    n.s1 = linkIn;
    n.s2 = s.s1;
    n.clkPrev = s.s2.clk;
    n.proto1 = receive_protocol_select;
    n.proto2 = s.proto1;
    linkEdge = s.s2.clk && !s.clkPrev;
    isCtl = s.s2.ctl;
    w = s.s2.dat;
    spiOn = !s.proto2 && s.ctrl[1:0] != PART_TWO && s.ctrl[1:0] != 2'h3;
    bAddr = 13'({s.elem, 6'h00} + 13'(s.off));
    rdSum = 16'(rdReq.srcA + rdReq.srcB) - RBUF_BASE;
    // Register bus; clears go before sets so sets win
    n.ack = 1'b0;
    n.datR = '0;
    if (wbReq.cyc && wbReq.stb && !s.ack) begin
      n.ack = 1'b1;
      if (wbReq.we && wbReq.sel[0]) begin
        if (wbReq.adr == REG_CTRL) n.ctrl = wbReq.dat[7:0];
        if (wbReq.adr == REG_STAT && wbReq.dat[0]) n.overflow = 1'b0;
        if (wbReq.adr == REG_FREE) n.inUse[wbReq.dat[6:0]] = 1'b0;
      end else if (!wbReq.we) begin
        if (wbReq.adr == REG_CTRL) n.datR = {24'h0, s.ctrl};
        if (wbReq.adr == REG_STAT) n.datR = {16'h0, 8'(fill), 5'h0, s.fsm, s.overflow};
      end
    end
    if (s.fsm != FILL_IDLE && dipError) n.tPar = 1'b1;
    // Link word handling
    if (clkEn && linkEdge && spiOn) begin
      if (isCtl) begin
        n.ctlHold = w;
        n.csum = '0;
        n.burstCnt = '0;
        if (s.fsm != FILL_IDLE) begin
          fifoWe = 1'b1;
          fifoData = closeStatus(s, w[14:13], 1'b1);
        end
        n.fsm = FILL_IDLE;
        if (w[CW_TYPE]) begin
          if (found) begin
            n.inUse[freeIdx] = 1'b1;
            n.elem = freeIdx;
            n.off = '0;
            n.byteCnt = '0;
            n.tType = w[CW_TYPE];
            n.tSop = w[CW_SOP];
            n.tAdr = w[11:4];
            n.tPar = 1'b0;
            n.fsm = FILL_ACTIVE;
          end else begin
            n.overflow = 1'b1;
          end
        end
      end else begin
        n.burstCnt = 4'(s.burstCnt + 4'h2);
        if (s.fsm == FILL_ACTIVE) begin
          memWe = 1'b1;
          memIdx = bAddr[12:2];
          memHigh = !bAddr[1];
          memData = w;
          n.off = 9'(s.off + 9'h2);
          n.byteCnt = 9'(s.byteCnt + 9'h2);
          n.csum = ocAdd(s.csum, w);
          n.lastByte = w[15:8];
          if (9'(s.off + 9'h2) == eBytes) n.fsm = FILL_PREVALID;
        end else if (s.fsm == FILL_PREVALID) begin
          fifoWe = 1'b1;
          fifoData = closeStatus(s, EOPS_NONE, 1'b0);
          n.fsm = FILL_IDLE;
          if (found) begin
            n.inUse[freeIdx] = 1'b1;
            n.elem = freeIdx;
            n.tSop = 1'b0;
            n.tPar = 1'b0;
            n.off = 9'h2;
            n.byteCnt = 9'h2;
            n.csum = w;
            n.lastByte = w[15:8];
            memWe = 1'b1;
            memIdx = 11'({freeIdx, 6'h00} >> 2);
            memHigh = 1'b1;
            memData = w;
            n.fsm = (eBytes == 9'h2) ? FILL_PREVALID : FILL_ACTIVE;
          end else begin
            n.overflow = 1'b1;
          end
        end
      end
    end
    // Null status when the queue slot is free this cycle
    n.pendNull = freelistTimeout || (s.pendNull && fifoWe);
    if (s.pendNull && !fifoWe) begin
      fifoWe = 1'b1;
      fifoData = '0;
      fifoData.nullBit = 1'b1;
    end
    if (fifoWe && fill != PW'(STQ_DEPTH)) n.wrPtr = PW'(s.wrPtr + 1'b1);
    // Output stage of the completed-element queue
    if ((!s.stValid || statusTake) && fill != '0) begin
      n.stOut = fifo[s.rdPtr[PW-2:0]];
      n.stValid = 1'b1;
      n.rdPtr = PW'(s.rdPtr + 1'b1);
    end else if (statusTake) begin
      n.stValid = 1'b0;
    end
    // Read engine; no write to data or element state here
    if (!s.rdActive && rdReq.start) begin
      n.rdWord = rdSum[12:2];
      n.rdDram = rdReq.toDram;
      n.rdPhase = 1'b0;
      n.rdLeft = (rdReq.toDram || rdReq.pairs) ? {1'b0, rdReq.count, 1'b0}
          : {2'h0, rdReq.count};
      n.rdActive = rdReq.count != 5'h0;
      n.push.xferReg = rdReq.xferReg;
      n.dram.addr = {rdReq.dramAddr[31:3], 3'h0};
    end else if (s.rdActive) begin
      n.rdWord = 11'(s.rdWord + 11'h1);
      n.rdLeft = 7'(s.rdLeft - 7'h1);
      n.rdActive = s.rdLeft != 7'h1;
      n.rdPhase = !s.rdPhase;
      if (!s.rdDram) begin
        n.push.valid = 1'b1;
        n.push.data = mem[s.rdWord];
        if (s.push.valid) n.push.xferReg = 7'(s.push.xferReg + 7'h1);
      end else if (!s.rdPhase) begin
        n.rdLow = mem[s.rdWord];
        // Step the address once the previous word has gone out
        if (s.dram.valid) n.dram.addr = 32'(s.dram.addr + 32'h8);
      end else begin
        n.dram.valid = 1'b1;
        n.dram.data = {mem[s.rdWord], s.rdLow};
      end
    end
  end

  // State register; reset leaves every element free
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.fsm <= FILL_IDLE;
    end else if (clkEn) begin
      s <= n;
    end
  end

  // Buffer and queue storage writes, halfword lanes big-endian
  always_ff @(posedge clk_sys) begin
    if (clkEn && memWe) begin
      if (memHigh) mem[memIdx][31:16] <= memData;
      else mem[memIdx][15:0] <= memData;
    end
    if (clkEn && fifoWe && fill != PW'(STQ_DEPTH)) fifo[s.wrPtr[PW-2:0]] <= fifoData;
  end

  // Outputs straight from state except wbUnused, which is tied to zero
  assign wbAck = s.ack;
  assign wbDatR = s.datR;
  assign wbUnused = '0;
  assign statusValid = s.stValid;
  assign statusWord = s.stOut;
  assign overflowFlag = s.overflow;
  assign rdBusy = s.rdActive;
  assign pushOut = s.push;
  assign dramOut = s.dram;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic payload;
  assign payload = clkEn && linkEdge && spiOn && isCtl && w[CW_TYPE];
  logic closing;
  assign closing = clkEn && linkEdge && spiOn && isCtl && s.fsm != FILL_IDLE;
  ovf_on_full_a: assert property (payload && !found |=> s.overflow)
    else $error("overflow not flagged");
  ctl_hold_a: assert property (clkEn && linkEdge && spiOn && isCtl |=>
    s.csum == 16'h0 && s.ctlHold == $past(w)) else $error("control word not held");
  alloc_init_a: assert property (payload && found |=>
    s.fsm == FILL_ACTIVE && s.byteCnt == 9'h0 && s.off == 9'h0) else $error("bad alloc");
  fill_prevalid_a: assert property (clkEn && linkEdge && spiOn && !isCtl &&
    s.fsm == FILL_ACTIVE && 9'(s.off + 9'h2) == eBytes |=> s.fsm == FILL_PREVALID)
    else $error("no pre-valid");
  prevalid_next_a: assert property (clkEn && linkEdge && spiOn && !isCtl &&
    s.fsm == FILL_PREVALID && found |=> s.byteCnt == 9'h2 && !s.tSop &&
    s.tAdr == $past(s.tAdr)) else $error("bad follow-on element");
  one_byte_a: assert property (closing && w[14:13] == EOPS_ONE |->
    fifoData.byteCount == 8'(s.byteCnt - 9'h1) && fifoData.eop) else $error("bad trim");
  abort_round_a: assert property (closing && w[14:13] == EOPS_ABORT |->
    fifoData.byteCount[1:0] == 2'h0 && fifoData.err && fifoData.abortErr)
    else $error("bad abort");
  elem_number_a: assert property (fifoWe && !fifoData.nullBit |->
    fifoData.element == s.elem && !fifoData.proto) else $error("bad element field");
  push_seq_a: assert property (s.push.valid && n.push.valid && clkEn |=>
    s.push.xferReg == 7'($past(s.push.xferReg) + 7'h1)) else $error("push not consecutive");
  null_word_a: assert property (clkEn && freelistTimeout |=>
    ##[0:1] (fifoWe && fifoData.nullBit)) else $error("null status not queued");
  prevalid_c: cover property (s.fsm == FILL_PREVALID ##1 s.fsm == FILL_ACTIVE);
  overflow_c: cover property ($rose(s.overflow));
  dram_c: cover property (s.dram.valid ##1 s.dram.valid);
  null_c: cover property (fifoWe && fifoData.nullBit);
endmodule // rx_buffer_spi4

// >>> test/spi4_phy_model.sv
// Far-side link model: drives control and data words with its own clock
`timescale 1ns/100ps
module spi4_phy_model (
  output rbuf_pkg::link_t link
);
  import rbuf_pkg::*;
  // Link clock stands low between words
  initial link = '0;
  // One transfer off the system edges, clock high 200 ns, data inverted after hold
  task automatic xfer(input logic ctl, input logic [15:0] dat);
    #10 link.ctl = ctl;
    link.dat = dat;
    #100 link.clk = 1'b1;
    #200 link.clk = 1'b0;
    #50 link.dat = ~dat;
    #40;
  endtask
  // Control word with type, end status, start flag and port
  task automatic ctlw(input logic typ, input logic [1:0] eops, input logic sop,
                      input logic [7:0] adr);
    xfer(1'b1, {typ, eops, sop & typ, adr, 4'h0});
  endtask
endmodule // spi4_phy_model

// >>> test/testbench.sv
// Self-checking bench for the receive buffer with a reference model
`timescale 1ns/100ps
module testbench;
  import rbuf_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        protoSel = 1'b0;
  logic        dipError = 1'b0;
  logic        freelistTimeout = 1'b0;
  logic        statusTake = 1'b0;
  logic        wbAck, statusValid, overflowFlag, rdBusy;
  logic [31:0] wbDatR;
  wb_req_t     wbReq = '0;
  link_t       linkIn;
  status_t     statusWord;
  rd_req_t     rdReq = '0;
  push_t       pushOut;
  dram_t       dramOut;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          seed = 23905;
  int          esz, elemLo, elemHi;
  status_t     expQ[$];
  logic [7:0]  mem[256];
  logic [6:0]  lastElem;
  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;
  rx_buffer_spi4 u_dut (.clk_sys(clk_sys), .reset(reset), .clkEn(1'b1), .wbReq(wbReq),
    .wbUnused(), .wbAck(wbAck), .wbDatR(wbDatR), .linkIn(linkIn),
    .receive_protocol_select(protoSel), .dipError(dipError),
    .freelistTimeout(freelistTimeout), .statusTake(statusTake), .statusValid(statusValid),
    .statusWord(statusWord), .overflowFlag(overflowFlag), .rdReq(rdReq), .rdBusy(rdBusy),
    .pushOut(pushOut), .dramOut(dramOut));
  spi4_phy_model u_phy (.link(linkIn));
  // Verdict and end of run
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tmo();
    chk("handshake", 1, 0);
    complete_run();
  endtask
  function automatic logic [31:0] word(input int o);
    return {mem[o], mem[o+1], mem[o+2], mem[o+3]};
  endfunction
  // Classic Wishbone single cycle
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    wbReq <= '{1'b1, 1'b1, we, adr, 4'hF, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      if (++n > 20) tmo();
    end while (wbAck !== 1'b1);
    q = wbDatR;
    wbReq <= '0;
    @(posedge clk_sys);
  endtask
  // Pop one status word from the queue
  task automatic getStat(output status_t s);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      if (++n > 400) tmo();
    end while (statusValid !== 1'b1);
    s = statusWord;
    statusTake <= 1'b1;
    @(posedge clk_sys);
    statusTake <= 1'b0;
  endtask
  // Send a burst, model its element statuses, compare in order
  task automatic pkt(input logic sop, input logic [7:0] adr, input int n,
                     input logic [1:0] eops, input logic dip);
    status_t e, g;
    logic [15:0] w;
    logic [16:0] s;
    int k, b;
    e = '0;
    e.typeBit = 1'b1;
    e.adr = adr;
    e.sop = sop;
    e.parErr = dip;
    b = 0;
    @(posedge clk_sys);
    dipError <= dip;
    u_phy.ctlw(1'b1, 2'h0, sop, adr);
    for (k = 0; k < n; k++) begin
      if (b == esz) begin
        e.byteCount = 8'(b);
        expQ.push_back(e);
        e.sop = 1'b0;
        e.checksum = '0;
        b = 0;
      end
      w = 16'($random(seed));
      if (k == n - 1 && eops == EOPS_ONE) w[7:0] = 8'h00;
      mem[b] = w[15:8];
      mem[b+1] = w[7:0];
      s = e.checksum + ((k == n - 1 && eops == EOPS_ONE) ? {8'h00, w[15:8]} : w);
      e.checksum = s[15:0] + 16'(s[16]);
      b += 2;
      u_phy.xfer(1'b0, w);
    end
    @(posedge clk_sys);
    dipError <= 1'b0;
    u_phy.ctlw(1'b0, eops, 1'b0, 8'h00);
    if (eops == EOPS_ONE) b--;
    if (eops == EOPS_ABORT) b = (b + 3) / 4 * 4;
    e.byteCount = 8'(b);
    e.eop = eops != EOPS_NONE;
    e.abortErr = eops == EOPS_ABORT;
    e.lenErr = eops == EOPS_NONE && b % 16 != 0;
    e.err = e.lenErr | e.parErr | e.abortErr;
    expQ.push_back(e);
    while (expQ.size() > 0) begin
      getStat(g);
      e = expQ.pop_front();
      chk("element place", 1, g.element >= elemLo && g.element < elemHi
          && g.element % (esz / 64) == 0);
      e.element = g.element;
      chk("status word", e, g);
      lastElem = g.element;
    end
  endtask
  // Engine read from byte 4 of the last element
  task automatic rd(input logic toDram, input logic pairs, input int cnt,
                    input logic [6:0] x, input logic [31:0] da);
    int n, i, w;
    @(posedge clk_sys);
    rdReq <= '{1'b1, toDram, pairs, 5'(cnt), RBUF_BASE + 16'({lastElem, 6'h00}),
               16'h0004, x, da};
    @(posedge clk_sys);
    rdReq.start <= 1'b0;
    w = (toDram || pairs) ? 2 * cnt : cnt;
    i = 0;
    n = 0;
    while (i < w) begin
      @(posedge clk_sys);
      if (++n > 200) tmo();
      if (n == 1) chk("read busy", 1, rdBusy);
      if (!toDram && pushOut.valid === 1'b1) begin
        chk("push register", 7'(x + i), pushOut.xferReg);
        chk("push data", word(4 + 4 * i), pushOut.data);
        i++;
      end
      if (toDram && dramOut.valid === 1'b1) begin
        chk("dram address", da + 4 * i, dramOut.addr);
        chk("dram data", {word(8 + 4 * i), word(4 + 4 * i)}, dramOut.data);
        i += 2;
      end
    end
    chk("read idle", 0, rdBusy);
  endtask
  // Main sequence
  initial begin
    status_t g;
    logic [31:0] q;
    int i;
    esz = 64;
    elemLo = 0;
    elemHi = 128;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    chk("status valid", 0, statusValid);
    chk("overflow", 0, overflowFlag);
    wb(1'b0, REG_CTRL, 0, q);
    chk("ctrl reset", CTRL_RST, q);
    wb(1'b1, 4'hC, 32'h5555_AAAA, q);
    wb(1'b0, 4'hC, 0, q);
    chk("unmapped read", 0, q);
    pkt(1'b1, 8'h5A, 16, 2'h2, 1'b0);
    rd(1'b0, 1'b0, 7, 7'h7E, 0);
    rd(1'b0, 1'b1, 3, 7'h10, 0);
    rd(1'b1, 1'b0, 3, 7'h00, 32'h0000_1238);
    rd(1'b0, 1'b0, 7, 7'h03, 0);
    for (i = 0; i < 4; i++) pkt(i[0], 8'(i * 37), 3, 2'(i), i == 1);
    pkt(1'b1, 8'h33, 33, EOPS_ONE, 1'b0);
    pkt(1'b1, 8'hC4, 32, 2'h2, 1'b0);
    // Idle words and foreign protocol produce nothing
    u_phy.ctlw(1'b0, 2'h0, 1'b0, 8'h00);
    @(posedge clk_sys);
    protoSel <= 1'b1;
    u_phy.ctlw(1'b1, 2'h0, 1'b1, 8'h11);
    u_phy.xfer(1'b0, 16'h1234);
    u_phy.ctlw(1'b0, 2'h2, 1'b0, 8'h00);
    repeat (40) @(posedge clk_sys);
    chk("no status", 0, statusValid);
    protoSel <= 1'b0;
    freelistTimeout <= 1'b1;
    @(posedge clk_sys);
    freelistTimeout <= 1'b0;
    getStat(g);
    chk("null bit", 1, g.nullBit);
    // Second reset, three partitions, 256-byte link elements
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    wb(1'b1, REG_CTRL, 32'h0000_0022, q);
    esz = 256;
    elemLo = 64;
    elemHi = 112;
    pkt(1'b0, 8'h81, 128, 2'h2, 1'b0);
    // One partition, 128-byte elements, burst spans two elements
    wb(1'b1, REG_CTRL, 32'h0000_0004, q);
    esz = 128;
    elemLo = 0;
    elemHi = 128;
    pkt(1'b1, 8'h42, 70, 2'h2, 1'b0);
    // Two partitions leave no room for link traffic
    wb(1'b1, REG_CTRL, 32'h0000_0001, q);
    u_phy.ctlw(1'b1, 2'h0, 1'b1, 8'h22);
    u_phy.xfer(1'b0, 16'h4321);
    u_phy.ctlw(1'b0, 2'h2, 1'b0, 8'h00);
    repeat (8) @(posedge clk_sys);
    chk("two partitions", 0, statusValid);
    wb(1'b1, REG_CTRL, 0, q);
    // Exhaust the elements
    for (i = 0; i < 140; i++) begin
      u_phy.ctlw(1'b1, 2'h0, 1'b1, 8'h01);
      u_phy.xfer(1'b0, 16'h0F0F);
      u_phy.ctlw(1'b0, 2'h2, 1'b0, 8'h00);
    end
    repeat (8) @(posedge clk_sys);
    chk("overflow flag", 1, overflowFlag);
    wb(1'b0, REG_STAT, 0, q);
    chk("stat overflow", 1, q[0]);
    wb(1'b1, REG_STAT, 1, q);
    wb(1'b0, REG_STAT, 0, q);
    chk("overflow cleared", 0, q[0]);
    complete_run();
  end
endmodule // testbench
